// file: src/irdp_map.svh
// Purpose: register offsets, field positions and reset values of the ram port
// Assumes: byte addressing on the register bus, one aligned 32-bit word each
// Notes:   definitions only
`ifndef IRDP_MAP_SVH
`define IRDP_MAP_SVH

// register offsets (byte addresses)
`define IRDP_SEL_OFS     8'h24
`define IRDP_CMD_OFS     8'h28
`define IRDP_ADDR_OFS    8'h2c
`define IRDP_WORD_OFS    8'h30

// field positions
`define IRDP_READY_BIT   31
`define IRDP_SEL_MSB     3
`define IRDP_DIR_BIT     0
`define IRDP_ADDR_MSB    13

// reset values
`define IRDP_READY_RST   1'b1
`define IRDP_SEL_RST     4'h0
`define IRDP_DIR_RST     1'b0
`define IRDP_ADDR_RST    14'h0000
`define IRDP_WORD_RST    32'h0000_0000

// direction values of the command bit
`define IRDP_DIR_WRITE   1'b1
`define IRDP_DIR_READ    1'b0

`endif

// file: src/irdp_pkg.sv
// Purpose: types shared by the indirect ram port
// Assumes: field widths as given in irdp_map.svh
// Notes:   select codes name the internal rams
package irdp_pkg;

    // target ram codes of the select field
    typedef enum logic [3:0] {
        IRDP_RAM_HOST_RX   = 4'h0,
        IRDP_RAM_VLAN_HASH = 4'h1,
        IRDP_RAM_SEG_HDR   = 4'h2,
        IRDP_RAM_FIFO_RX   = 4'h3,
        IRDP_RAM_FIFO_TX   = 4'h4,
        IRDP_RAM_DESC      = 4'h5,
        IRDP_RAM_HOST_TX   = 4'h7
    } irdp_ram_sel_t;

    // one access request towards the internal rams
    typedef struct packed {
        logic        req;
        logic        we;
        logic [3:0]  sel;
        logic [13:0] addr;
        logic [31:0] wdata;
    } irdp_ram_req_t;

    // port sequencer states
    typedef enum logic {
        IRDP_IDLE,
        IRDP_ACCESS
    } irdp_state_t;

endpackage

// file: src/irdp_top.sv
// Purpose: indirect ram port, register bank on an Avalon-MM slave
// Assumes: ram side holds ram_rdata_i valid in the cycle of ram_ack_i
// Notes:   a command written while busy is stored but starts no access
`include "irdp_map.svh"
`timescale 1ns/100ps
`default_nettype none

module irdp_top (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // avalon-mm register slave
    input  wire logic [7:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // internal ram access
    output irdp_pkg::irdp_ram_req_t    ram_o,
    input  wire logic                  ram_ack_i,
    input  wire logic [31:0]           ram_rdata_i
);

    // register state
    logic                     ready_q;
    logic [3:0]               sel_q;
    logic                     dir_q;
    logic [13:0]              addr_q;
    logic [31:0]              word_q;
    irdp_pkg::irdp_state_t    state_q;
    irdp_pkg::irdp_ram_req_t  ram_q;
    logic                     wait_q;
    logic [31:0]              rdata_q;

    // bus decode
    logic                     wr_commit;
    logic                     cmd_commit;
    logic                     rd_done;
    logic [31:0]              wr_val;

    // readback of the addressed register, zero for unmapped offsets
    function automatic logic [31:0] read_mux(
        input logic [7:0]  ofs,
        input logic        rdy,
        input logic [3:0]  sel,
        input logic        dir,
        input logic [13:0] adr,
        input logic [31:0] wrd
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (ofs)
            `IRDP_SEL_OFS: begin
                v[`IRDP_READY_BIT] = rdy;
                v[`IRDP_SEL_MSB:0] = sel;
            end
            `IRDP_CMD_OFS: begin
                v[`IRDP_DIR_BIT] = dir;
            end
            `IRDP_ADDR_OFS: begin
                v[`IRDP_ADDR_MSB:0] = adr;
            end
            `IRDP_WORD_OFS: begin
                v = wrd;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // merge enabled byte lanes of new data over the old word
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // a request completes at the edge where waitrequest is seen low
    assign wr_commit  = avs_write_i && !wait_q;
    assign cmd_commit = wr_commit && (avs_address_i == `IRDP_CMD_OFS)
                        && avs_byteenable_i[0];
    assign rd_done    = (state_q == irdp_pkg::IRDP_ACCESS) && ram_ack_i
                        && (ram_q.we == `IRDP_DIR_READ);
    assign wr_val     = be_merge(read_mux(avs_address_i, ready_q, sel_q, dir_q,
                                          addr_q, word_q),
                                 avs_writedata_i, avs_byteenable_i);

    // waitrequest: one wait cycle, then a single cycle low to complete
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // read data is captured in the wait cycle and stands at completion
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            rdata_q <= read_mux(avs_address_i, ready_q, sel_q, dir_q,
                                addr_q, word_q);
        end
    end

    // select field, stored as written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= `IRDP_SEL_RST;
        end else if (wr_commit && (avs_address_i == `IRDP_SEL_OFS)) begin
            sel_q <= wr_val[`IRDP_SEL_MSB:0];
        end
    end

    // command direction bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= `IRDP_DIR_RST;
        end else if (cmd_commit) begin
            dir_q <= wr_val[`IRDP_DIR_BIT];
        end
    end

    // word address, upper bits not stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= `IRDP_ADDR_RST;
        end else if (wr_commit && (avs_address_i == `IRDP_ADDR_OFS)) begin
            addr_q <= wr_val[`IRDP_ADDR_MSB:0];
        end
    end

    // data word: read result wins over a software write in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_q <= `IRDP_WORD_RST;
        end else if (rd_done) begin
            word_q <= ram_rdata_i;
        end else if (wr_commit && (avs_address_i == `IRDP_WORD_OFS)) begin
            word_q <= wr_val;
        end
    end

    // sequencer: launches the ram access and drives the ready flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= irdp_pkg::IRDP_IDLE;
            ready_q <= `IRDP_READY_RST;
            ram_q   <= '0;
        end else begin
            case (state_q)
                irdp_pkg::IRDP_IDLE: begin
                    if (cmd_commit) begin
                        state_q     <= irdp_pkg::IRDP_ACCESS;
                        ready_q     <= 1'b0;
                        ram_q.req   <= 1'b1;
                        ram_q.we    <= wr_val[`IRDP_DIR_BIT];
                        ram_q.sel   <= sel_q;
                        ram_q.addr  <= addr_q;
                        ram_q.wdata <= word_q;
                    end
                end
                irdp_pkg::IRDP_ACCESS: begin
                    if (ram_ack_i) begin
                        state_q   <= irdp_pkg::IRDP_IDLE;
                        ready_q   <= 1'b1;
                        ram_q.req <= 1'b0;
                    end
                end
                default: begin
                    state_q <= irdp_pkg::IRDP_IDLE;
                    ready_q <= 1'b1;
                    ram_q   <= '0;
                end
            endcase
        end
    end

    // outputs straight from flops
    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign ram_o             = ram_q;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a command taken while idle
    sequence s_start;
        cmd_commit && (state_q == irdp_pkg::IRDP_IDLE);
    endsequence

    // the ram keeps the port waiting for two cycles
    sequence s_slow_ram;
        !ram_ack_i [*2];
    endsequence

    // an access is open and the ram has not answered yet
    sequence s_open;
        (state_q == irdp_pkg::IRDP_ACCESS) && !ram_ack_i;
    endsequence

    property p_held_busy;
        s_start ##1 s_slow_ram |-> ram_q.req && !ready_q;
    endproperty

    a_ready_drop: assert property (s_start |=> !ready_q)
        else $error("ready flag not cleared by command");

    a_busy_held: assert property (p_held_busy)
        else $error("ready flag or request dropped during access");

    a_idle_ready: assert property ((state_q == irdp_pkg::IRDP_IDLE) |-> ready_q)
        else $error("ready flag low while idle");

    a_read_capture: assert property (rd_done |=> ready_q && word_q == $past(ram_rdata_i))
        else $error("read word not in data register when ready");

    a_ready_read: assert property (
        avs_read_i && wait_q && avs_address_i == `IRDP_SEL_OFS
        |=> !wait_q && avs_readdata_o[`IRDP_READY_BIT] == $past(ready_q))
        else $error("ready bit not reported in select readback");

    a_start_dir: assert property (
        s_start
        |=> ram_o.req && ram_o.we == $past(avs_writedata_i[`IRDP_DIR_BIT]))
        else $error("command write did not start access with its direction");

    a_dir_store: assert property (
        cmd_commit
        |=> dir_q == $past(avs_writedata_i[`IRDP_DIR_BIT]))
        else $error("direction bit not stored");

    a_sel_route: assert property (s_start |=> ram_o.sel == $past(sel_q))
        else $error("select code not routed to ram");

    a_addr_route: assert property (s_start |=> ram_o.addr == $past(addr_q))
        else $error("word address not routed to ram");

    a_word_route: assert property (s_start |=> ram_o.wdata == $past(word_q))
        else $error("data word not routed to ram");

    a_addr_upper: assert property (
        avs_read_i && wait_q && avs_address_i == `IRDP_ADDR_OFS
        |=> (avs_readdata_o >> (`IRDP_ADDR_MSB + 1)) == 32'h0000_0000)
        else $error("reserved address bits read nonzero");

    a_ack_finish: assert property (
        (state_q == irdp_pkg::IRDP_ACCESS) && ram_ack_i
        |=> (ready_q && !ram_o.req) ##1 (ready_q || $past(cmd_commit)))
        else $error("access did not finish on acknowledge");

    // access sequencing while the ram is still working
    a_fields_hold: assert property (
        s_open |=> ram_o.req && !ready_q && $stable(ram_o))
        else $error("request fields or busy flag moved during access");

    a_busy_refuse: assert property (
        s_open ##0 cmd_commit |=> !ready_q && $stable(ram_o))
        else $error("command taken while busy disturbed the access");

    // register readback against the stored fields
    a_word_read: assert property (
        avs_read_i && wait_q && avs_address_i == `IRDP_WORD_OFS
        |=> avs_readdata_o == $past(word_q))
        else $error("data word readback differs from register");

    a_cmd_read: assert property (
        avs_read_i && wait_q && avs_address_i == `IRDP_CMD_OFS
        |=> avs_readdata_o[`IRDP_DIR_BIT] == $past(dir_q)
            && (avs_readdata_o >> (`IRDP_DIR_BIT + 1)) == 32'h0000_0000)
        else $error("command readback differs from direction bit");

    a_sel_read: assert property (
        avs_read_i && wait_q && avs_address_i == `IRDP_SEL_OFS
        |=> avs_readdata_o[`IRDP_SEL_MSB:0] == $past(sel_q))
        else $error("select readback differs from select field");

endmodule

`default_nettype wire

// file: verification/irdp_tb.sv
// Purpose: self-checking bench for the indirect ram port
// Assumes: ram side modelled here, acks 7 to 11 cycles after req rises
// Notes:   expected ram words and register values come from a bench model
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // clock and reset
    logic                    clk_i;
    logic                    rst_i;
    // register bus
    logic [7:0]              avs_address_i;
    logic                    avs_read_i;
    logic                    avs_write_i;
    logic [31:0]             avs_writedata_i;
    logic [3:0]              avs_byteenable_i;
    logic [31:0]             avs_readdata_o;
    logic                    avs_waitrequest_o;
    // ram side
    irdp_pkg::irdp_ram_req_t ram_o;
    logic                    ram_ack_i;
    logic [31:0]             ram_rdata_i;
    // bench state
    int                      error_cnt;
    int                      checks;
    int                      acc_cnt;
    int                      wait_n;
    int                      cyc;
    int                      n0;
    logic [31:0]             mem [int];
    logic [31:0]             got;
    logic                    exp_we;
    logic [3:0]              exp_sel;
    logic [13:0]             exp_addr;
    logic [31:0]             exp_wd;
    logic [3:0]              codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};

    irdp_top u_dut (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .ram_o             (ram_o),
        .ram_ack_i         (ram_ack_i),
        .ram_rdata_i       (ram_rdata_i)
    );

    // clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= wd;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        chk("bus latency", 32'h0000_0002, 32'(n));
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    // poll the select register until the port reports idle
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h24, 32'h0000_0000, got);
            n++;
        end while (got[31] !== 1'b1 && n < 100);
        chk("ready", 32'h0000_0001, {31'h0, got[31]});
    endtask

    // start one access and follow it to completion
    task automatic access(input logic dir);
        n0 = acc_cnt;
        exp_we = dir;
        wr(8'h28, {31'h0, dir});
        rd(8'h24, {28'h000_0000, exp_sel}, "busy select");
        wait_ready();
        chk("accesses", 32'(n0 + 1), 32'(acc_cnt));
    endtask

    // ram side: checks the request fields, acks after a random delay
    always @(posedge clk_i) begin
        if (ram_o.req === 1'b1 && ram_ack_i !== 1'b1 && wait_n == 1) begin
            ram_ack_i <= 1'b1;
            wait_n    <= 0;
            acc_cnt++;
            if (ram_o.we) begin
                mem[{ram_o.sel, ram_o.addr}] = ram_o.wdata;
                ram_rdata_i <= $urandom;
            end else begin
                ram_rdata_i <= mem.exists({ram_o.sel, ram_o.addr}) ?
                               mem[{ram_o.sel, ram_o.addr}] : 32'h0000_0000;
            end
        end else begin
            ram_ack_i   <= 1'b0;
            ram_rdata_i <= $urandom;
            if (ram_o.req === 1'b1 && ram_ack_i !== 1'b1) begin
                if (wait_n == 0) begin
                    chk("ram we", {31'h0, exp_we}, {31'h0, ram_o.we});
                    chk("ram sel", {28'h0, exp_sel}, {28'h0, ram_o.sel});
                    chk("ram addr", {18'h0, exp_addr}, {18'h0, ram_o.addr});
                    if (exp_we) chk("ram wdata", exp_wd, ram_o.wdata);
                    wait_n <= 6 + $urandom_range(0, 4);
                end else begin
                    wait_n <= wait_n - 1;
                end
            end
        end
    end

    // cut a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // main sequence
    initial begin
        void'($urandom(15));
        rst_i = 1'b1;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hf;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h24, 32'h8000_0000, "select reset");
        rd(8'h28, 32'h0000_0000, "command reset");
        rd(8'h2c, 32'h0000_0000, "address reset");
        rd(8'h30, 32'h0000_0000, "word reset");
        rd(8'h10, 32'h0000_0000, "unmapped");
        wr(8'h2c, 32'hffff_ffff);
        rd(8'h2c, 32'h0000_3fff, "address mask");
        // byte lanes: only enabled lanes change, lane 0 off starts nothing
        avs_byteenable_i <= 4'h2;
        wr(8'h2c, 32'h0000_1200);
        rd(8'h2c, 32'h0000_12ff, "address lanes");
        n0 = acc_cnt;
        wr(8'h28, 32'h0000_0001);
        rd(8'h24, 32'h8000_0000, "lane0 off select");
        chk("lane0 off accesses", 32'(n0), 32'(acc_cnt));
        rd(8'h28, 32'h0000_0000, "lane0 off dir");
        avs_byteenable_i <= 4'hf;
        wr(8'h24, 32'hffff_fff1);
        rd(8'h24, 32'h8000_0001, "select mask");
        $display("test reset and masks done");
        // every select code, write then read back
        foreach (codes[i]) begin
            exp_sel  = codes[i];
            exp_addr = 14'($urandom_range(0, 16383));
            exp_wd   = $urandom;
            wr(8'h24, {28'h0, exp_sel});
            wr(8'h2c, {18'h0, exp_addr});
            wr(8'h30, exp_wd);
            access(1'b1);
            rd(8'h28, 32'h0000_0001, "command write dir");
            wr(8'h30, ~exp_wd);
            access(1'b0);
            rd(8'h30, exp_wd, "read word");
            rd(8'h28, 32'h0000_0000, "command read dir");
        end
        $display("test select codes done");
        // a command written while busy starts nothing
        n0 = acc_cnt;
        exp_we = 1'b1;
        wr(8'h28, 32'h0000_0001);
        wr(8'h28, 32'h0000_0000);
        rd(8'h24, {28'h000_0000, exp_sel}, "busy flag held");
        wait_ready();
        chk("busy accesses", 32'(n0 + 1), 32'(acc_cnt));
        rd(8'h28, 32'h0000_0000, "busy command dir");
        $display("test busy command done");
        report_and_stop();
    end
endmodule

`default_nettype wire
